// *** cache_op_protect_pkg.sv ***
// Constants, types and register map of the cache operation access checker.
// Assumes one clock domain shared with the pipeline and a plain register port.
package cache_op_protect_pkg;

   localparam logic [7:0]  WRITE_THROUGH_OFFSET  = 8'h00;
   localparam logic [7:0]  DATA_CACHABLE_OFFSET  = 8'h04;
   localparam logic [7:0]  INSTR_CACHABLE_OFFSET = 8'h08;
   localparam logic [7:0]  GUARDED_OFFSET        = 8'h0C;
   localparam logic [7:0]  USER_DEFINED_OFFSET   = 8'h10;
   localparam logic [7:0]  LITTLE_ENDIAN_OFFSET  = 8'h14;
   localparam logic [7:0]  EVENT_COUNT_OFFSET    = 8'h18;

   localparam logic [31:0] REGION_CLEAR_RESET    = 32'h0000_0000;
   localparam logic [31:0] GUARDED_RESET         = 32'hFFFF_FFFF;
   localparam logic [31:0] READ_ZERO             = 32'h0000_0000;
   localparam logic [15:0] COUNT_RESET           = 16'h0000;
   localparam logic [15:0] COUNT_STEP            = 16'h0001;
   localparam logic [15:0] COUNT_SATURATED       = 16'hFFFF;
   localparam logic [1:0]  ZONE_NO_ACCESS        = 2'h0;
   localparam logic [6:0]  STRING_COUNT_EMPTY    = 7'h00;
   localparam int          REGION_INDEX_MSB      = 31;
   localparam int          REGION_INDEX_LSB      = 27;

   typedef enum logic [3:0] {
      OP_DATA_ALLOCATE,
      OP_DATA_FLUSH,
      OP_DATA_INVALIDATE,
      OP_DATA_STORE_BLOCK,
      OP_DATA_TOUCH,
      OP_DATA_TOUCH_STORE,
      OP_DATA_ZERO,
      OP_DATA_CLASS_INVALIDATE,
      OP_DATA_DEBUG_READ,
      OP_INSTR_INVALIDATE,
      OP_INSTR_TOUCH,
      OP_INSTR_CLASS_INVALIDATE,
      OP_INSTR_DEBUG_READ,
      OP_LOAD_STRING,
      OP_STORE_STRING
   } op_t;

   typedef struct packed {
      logic write_through;
      logic cache_inhibit;
      logic guarded;
      logic user_defined;
      logic little_endian;
   } attr_t;

   typedef struct packed {
      op_t        op;
      logic [31:0] ea;
      logic [1:0] zone_protection_field;
      logic       page_write_permit;
      logic       problem_state;
      logic       data_translation_enable;
      logic       tlb_hit;
      logic [6:0] string_byte_count;
      attr_t      page_attr;
   } req_t;

   typedef struct packed {
      logic  data_storage_int;
      logic  tlb_miss_int;
      logic  no_op;
      logic  perform;
      logic  line_fill_allowed;
      attr_t attr;
   } resp_t;

endpackage

// *** cache_op_protect.sv ***
// Access checker for cache control and indexed string operations.
// Assumes requests and register strobes come from logic on REF_CLK.
`timescale 1ns/1ns
module cache_op_protect (
   input  wire logic                       REF_CLK,
   input  wire logic                       SYS_RST,
   input  wire logic                       REQ_VALID,
   input  wire cache_op_protect_pkg::req_t REQ,
   output logic                            RESP_VALID,
   output cache_op_protect_pkg::resp_t     RESP,
   input  wire logic [7:0]                 REG_ADDR,
   input  wire logic [31:0]                REG_WDATA,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   output logic [31:0]                     REG_RDATA
);

   // Region registers. There is deliberately no coherence register.
   logic [31:0] write_through_regions;
   logic [31:0] data_cachable_regions;
   logic [31:0] instr_cachable_regions;
   logic [31:0] guarded_regions;
   logic [31:0] user_defined_regions;
   logic [31:0] little_endian_regions;
   logic [15:0] fault_count;
   logic [15:0] miss_count;
   logic [31:0] next_write_through_regions;
   logic [31:0] next_data_cachable_regions;
   logic [31:0] next_instr_cachable_regions;
   logic [31:0] next_guarded_regions;
   logic [31:0] next_user_defined_regions;
   logic [31:0] next_little_endian_regions;
   logic [15:0] next_fault_count;
   logic [15:0] next_miss_count;
   logic [31:0] next_reg_rdata;
   logic        next_resp_valid;
   cache_op_protect_pkg::resp_t next_resp;

   // One decoder shared by every attribute register.
   function automatic logic region_bit(input logic [31:0] regions, input logic [31:0] ea);
      logic [4:0] index;
      index = ea[cache_op_protect_pkg::REGION_INDEX_MSB:cache_op_protect_pkg::REGION_INDEX_LSB];
      region_bit = regions[index];
   endfunction

   // Register file.
   always_comb begin
      next_write_through_regions  = write_through_regions;
      next_data_cachable_regions  = data_cachable_regions;
      next_instr_cachable_regions = instr_cachable_regions;
      next_guarded_regions        = guarded_regions;
      next_user_defined_regions   = user_defined_regions;
      next_little_endian_regions  = little_endian_regions;
      next_reg_rdata              = cache_op_protect_pkg::READ_ZERO;
      if (REG_WR) begin
         if (REG_ADDR == cache_op_protect_pkg::WRITE_THROUGH_OFFSET) begin
            next_write_through_regions = REG_WDATA;
         end else if (REG_ADDR == cache_op_protect_pkg::DATA_CACHABLE_OFFSET) begin
            next_data_cachable_regions = REG_WDATA;
         end else if (REG_ADDR == cache_op_protect_pkg::INSTR_CACHABLE_OFFSET) begin
            next_instr_cachable_regions = REG_WDATA;
         end else if (REG_ADDR == cache_op_protect_pkg::GUARDED_OFFSET) begin
            next_guarded_regions = REG_WDATA;
         end else if (REG_ADDR == cache_op_protect_pkg::USER_DEFINED_OFFSET) begin
            next_user_defined_regions = REG_WDATA;
         end else if (REG_ADDR == cache_op_protect_pkg::LITTLE_ENDIAN_OFFSET) begin
            next_little_endian_regions = REG_WDATA;
         end
      end
      if (REG_RD) begin
         if (REG_ADDR == cache_op_protect_pkg::WRITE_THROUGH_OFFSET) begin
            next_reg_rdata = write_through_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::DATA_CACHABLE_OFFSET) begin
            next_reg_rdata = data_cachable_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::INSTR_CACHABLE_OFFSET) begin
            next_reg_rdata = instr_cachable_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::GUARDED_OFFSET) begin
            next_reg_rdata = guarded_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::USER_DEFINED_OFFSET) begin
            next_reg_rdata = user_defined_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::LITTLE_ENDIAN_OFFSET) begin
            next_reg_rdata = little_endian_regions;
         end else if (REG_ADDR == cache_op_protect_pkg::EVENT_COUNT_OFFSET) begin
            next_reg_rdata = {fault_count, miss_count};
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         write_through_regions  <= cache_op_protect_pkg::REGION_CLEAR_RESET;
         data_cachable_regions  <= cache_op_protect_pkg::REGION_CLEAR_RESET;
         instr_cachable_regions <= cache_op_protect_pkg::REGION_CLEAR_RESET;
         guarded_regions        <= cache_op_protect_pkg::GUARDED_RESET;
         user_defined_regions   <= cache_op_protect_pkg::REGION_CLEAR_RESET;
         little_endian_regions  <= cache_op_protect_pkg::REGION_CLEAR_RESET;
         REG_RDATA              <= cache_op_protect_pkg::READ_ZERO;
      end else begin
         write_through_regions  <= next_write_through_regions;
         data_cachable_regions  <= next_data_cachable_regions;
         instr_cachable_regions <= next_instr_cachable_regions;
         guarded_regions        <= next_guarded_regions;
         user_defined_regions   <= next_user_defined_regions;
         little_endian_regions  <= next_little_endian_regions;
         REG_RDATA              <= next_reg_rdata;
      end
   end

   // Protection decision. A miss is checked first because without a page
   // entry neither zone nor permit is known.
   logic translate;
   logic zone_deny;
   logic write_deny;
   logic miss;
   logic instr_side;
   logic count_empty;

   always_comb begin
      translate   = REQ.data_translation_enable;
      // Only problem state accesses with translation on are refused by a zero zone.
      zone_deny   = translate && REQ.problem_state &&
                    (REQ.zone_protection_field == cache_op_protect_pkg::ZONE_NO_ACCESS);
      write_deny  = translate && !REQ.page_write_permit;
      miss        = translate && !REQ.tlb_hit;
      count_empty = (REQ.string_byte_count == cache_op_protect_pkg::STRING_COUNT_EMPTY);
      instr_side  = 1'b0;
      next_resp   = '0;
      next_resp.line_fill_allowed = 1'b1;
      case (REQ.op)
         cache_op_protect_pkg::OP_DATA_ALLOCATE: begin
            // Speculative, so any refusal quietly drops the operation.
            next_resp.no_op = zone_deny || write_deny || miss;
            next_resp.line_fill_allowed = 1'b0;
         end
         cache_op_protect_pkg::OP_DATA_FLUSH,
         cache_op_protect_pkg::OP_DATA_STORE_BLOCK: begin
            next_resp.tlb_miss_int     = miss;
            next_resp.data_storage_int = !miss && zone_deny;
         end
         cache_op_protect_pkg::OP_DATA_INVALIDATE: begin
            next_resp.tlb_miss_int     = miss;
            next_resp.data_storage_int = !miss && write_deny;
         end
         cache_op_protect_pkg::OP_DATA_TOUCH,
         cache_op_protect_pkg::OP_DATA_TOUCH_STORE: begin
            next_resp.no_op = zone_deny || miss;
         end
         cache_op_protect_pkg::OP_DATA_ZERO: begin
            next_resp.tlb_miss_int     = miss;
            next_resp.data_storage_int = !miss && (write_deny || zone_deny);
         end
         cache_op_protect_pkg::OP_DATA_CLASS_INVALIDATE: begin
            next_resp.tlb_miss_int     = miss;
            // The operand is checked as if it named one line.
            next_resp.data_storage_int = !miss && write_deny;
         end
         cache_op_protect_pkg::OP_DATA_DEBUG_READ: begin
            next_resp.data_storage_int = 1'b0;
         end
         cache_op_protect_pkg::OP_INSTR_INVALIDATE: begin
            instr_side = 1'b1;
            next_resp.tlb_miss_int     = miss;
            next_resp.data_storage_int = !miss && zone_deny;
         end
         cache_op_protect_pkg::OP_INSTR_TOUCH: begin
            instr_side = 1'b1;
            next_resp.no_op = zone_deny || miss;
         end
         cache_op_protect_pkg::OP_INSTR_CLASS_INVALIDATE: begin
            instr_side = 1'b1;
            next_resp.tlb_miss_int = miss;
         end
         cache_op_protect_pkg::OP_INSTR_DEBUG_READ: begin
            instr_side = 1'b1;
            next_resp.data_storage_int = 1'b0;
         end
         cache_op_protect_pkg::OP_LOAD_STRING: begin
            if (count_empty) begin
               next_resp.no_op = 1'b1;
            end else begin
               next_resp.tlb_miss_int     = miss;
               next_resp.data_storage_int = !miss && zone_deny;
            end
         end
         cache_op_protect_pkg::OP_STORE_STRING: begin
            if (count_empty) begin
               next_resp.no_op = 1'b1;
            end else begin
               next_resp.tlb_miss_int     = miss;
               next_resp.data_storage_int = !miss && (zone_deny || write_deny);
            end
         end
         default: begin
            next_resp.no_op = 1'b1;
         end
      endcase
      // A faulting or dropped operation must not touch cache or memory.
      next_resp.perform = !next_resp.data_storage_int && !next_resp.tlb_miss_int &&
                          !next_resp.no_op;
      if (!next_resp.perform) begin
         next_resp.line_fill_allowed = 1'b0;
      end
      if (translate) begin
         next_resp.attr = REQ.page_attr;
      end else begin
         next_resp.attr.write_through = region_bit(write_through_regions, REQ.ea);
         // A set cachable bit means caching is enabled.
         next_resp.attr.cache_inhibit = instr_side ?
                                        !region_bit(instr_cachable_regions, REQ.ea) :
                                        !region_bit(data_cachable_regions, REQ.ea);
         next_resp.attr.guarded       = region_bit(guarded_regions, REQ.ea);
         next_resp.attr.user_defined  = region_bit(user_defined_regions, REQ.ea);
         next_resp.attr.little_endian = region_bit(little_endian_regions, REQ.ea);
      end
      if (!REQ_VALID) begin
         next_resp = '0;
      end
      next_resp_valid = REQ_VALID;
      // Counters saturate rather than wrap so a long run is never misread as quiet.
      next_fault_count = fault_count;
      next_miss_count  = miss_count;
      if (next_resp.data_storage_int &&
          (fault_count != cache_op_protect_pkg::COUNT_SATURATED)) begin
         next_fault_count = fault_count + cache_op_protect_pkg::COUNT_STEP;
      end
      if (next_resp.tlb_miss_int &&
          (miss_count != cache_op_protect_pkg::COUNT_SATURATED)) begin
         next_miss_count = miss_count + cache_op_protect_pkg::COUNT_STEP;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         RESP_VALID  <= 1'b0;
         RESP        <= '0;
         fault_count <= cache_op_protect_pkg::COUNT_RESET;
         miss_count  <= cache_op_protect_pkg::COUNT_RESET;
      end else begin
         RESP_VALID  <= next_resp_valid;
         RESP        <= next_resp;
         fault_count <= next_fault_count;
         miss_count  <= next_miss_count;
      end
   end

endmodule

// *** cache_op_protect_props.sv ***
// Concurrent checks on the ports of the cache operation access checker.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cache_op_protect_props (
   input wire logic                        REF_CLK,
   input wire logic                        SYS_RST,
   input wire logic                        REQ_VALID,
   input wire cache_op_protect_pkg::req_t  REQ,
   input wire logic                        RESP_VALID,
   input wire cache_op_protect_pkg::resp_t RESP
);
   logic                       tv;
   logic                       zd;
   cache_op_protect_pkg::op_t  op;
   assign tv = REQ_VALID && REQ.data_translation_enable && REQ.tlb_hit;
   assign zd = REQ.problem_state && REQ.zone_protection_field == 2'h0;
   assign op = REQ.op;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   chk_alloc_quiet: assert property (REQ_VALID &&
      op == cache_op_protect_pkg::OP_DATA_ALLOCATE |=>
      RESP_VALID && !RESP.data_storage_int && !RESP.tlb_miss_int && !RESP.line_fill_allowed)
      else $error("allocate raised an interrupt or a fill");
   chk_zero_write_deny: assert property (tv && op == cache_op_protect_pkg::OP_DATA_ZERO &&
      !REQ.page_write_permit |=> RESP.data_storage_int) else $error("block zero not denied");
   chk_inv_zone_free: assert property (tv &&
      op == cache_op_protect_pkg::OP_DATA_INVALIDATE &&
      REQ.page_write_permit |=> !RESP.data_storage_int) else $error("invalidate zone fault");
   chk_class_write: assert property (tv &&
      op == cache_op_protect_pkg::OP_DATA_CLASS_INVALIDATE
      |=> RESP.data_storage_int == !$past(REQ.page_write_permit))
      else $error("class fault wrong");
   chk_flush_zone: assert property (tv && (op == cache_op_protect_pkg::OP_DATA_FLUSH ||
      op == cache_op_protect_pkg::OP_DATA_STORE_BLOCK) |=> RESP.data_storage_int == $past(zd))
      else $error("flush fault wrong");
   chk_touch_quiet: assert property (REQ_VALID &&
      (op == cache_op_protect_pkg::OP_DATA_TOUCH ||
      op == cache_op_protect_pkg::OP_DATA_TOUCH_STORE) |=> !RESP.data_storage_int &&
      !RESP.tlb_miss_int) else $error("touch raised an interrupt");
   chk_debug_quiet: assert property (REQ_VALID &&
      (op == cache_op_protect_pkg::OP_DATA_DEBUG_READ
      || op == cache_op_protect_pkg::OP_INSTR_DEBUG_READ) |=> !RESP.data_storage_int &&
      !RESP.tlb_miss_int) else $error("debug read raised an interrupt");
   chk_itouch_quiet: assert property (REQ_VALID &&
      op == cache_op_protect_pkg::OP_INSTR_TOUCH |=>
      !RESP.data_storage_int && !RESP.tlb_miss_int)
      else $error("instruction touch raised an interrupt");
   chk_iinv_zone: assert property (tv &&
      op == cache_op_protect_pkg::OP_INSTR_INVALIDATE |=> RESP.data_storage_int == $past(zd))
      else $error("instruction invalidate fault wrong");
   chk_iclass_no_fault: assert property (REQ_VALID &&
      op == cache_op_protect_pkg::OP_INSTR_CLASS_INVALIDATE |=> !RESP.data_storage_int)
      else $error("instruction class invalidate faulted");
   chk_string_empty: assert property (REQ_VALID && REQ.string_byte_count == 7'h00 &&
      (op == cache_op_protect_pkg::OP_LOAD_STRING || op == cache_op_protect_pkg::OP_STORE_STRING)
      |=> RESP.no_op && !RESP.perform && !RESP.data_storage_int && !RESP.tlb_miss_int)
      else $error("empty string not a no-op");
   chk_real_no_deny: assert property (REQ_VALID && !REQ.data_translation_enable |=>
      !RESP.data_storage_int) else $error("real mode fault");
   chk_fault_no_effect: assert property (RESP_VALID && RESP.data_storage_int |->
      !RESP.perform && !RESP.line_fill_allowed) else $error("fault with side effect");
endmodule
bind cache_op_protect cache_op_protect_props cache_op_protect_props_i (
   .REF_CLK    (REF_CLK),
   .SYS_RST    (SYS_RST),
   .REQ_VALID  (REQ_VALID),
   .REQ        (REQ),
   .RESP_VALID (RESP_VALID),
   .RESP       (RESP)
);

// *** cache_op_protect_tb.sv ***
// Self-checking bench for the cache operation access checker.
// Assumes the checker is bound from its own file; one clock at 250 MHz.
`timescale 1ns/1ns
module cache_op_protect_tb;
   logic                        REF_CLK = 1'h0;
   logic                        SYS_RST = 1'h1;
   logic                        REQ_VALID = 1'h0;
   cache_op_protect_pkg::req_t  REQ = '0;
   logic                        RESP_VALID;
   cache_op_protect_pkg::resp_t RESP;
   logic [7:0]                  REG_ADDR = 8'h00;
   logic [31:0]                 REG_WDATA = 32'h0000_0000;
   logic                        REG_WR = 1'h0;
   logic                        REG_RD = 1'h0;
   logic [31:0]                 REG_RDATA;
   int                          fail_count = 0;
   int                          n_compared = 0;
   int                          cycles = 0;
   cache_op_protect_pkg::resp_t r;
   // Per-op masks, bit i is op code i.
   localparam logic [14:0] ZONE_DSI = 15'h624A;
   localparam logic [14:0] ZONE_NOP = 15'h0431;
   localparam logic [14:0] WP_DSI   = 15'h40C4;
   localparam logic [14:0] MISS     = 15'h6ACE;

   cache_op_protect cache_op_protect_i (
      .REF_CLK    (REF_CLK),
      .SYS_RST    (SYS_RST),
      .REQ_VALID  (REQ_VALID),
      .REQ        (REQ),
      .RESP_VALID (RESP_VALID),
      .RESP       (RESP),
      .REG_ADDR   (REG_ADDR),
      .REG_WDATA  (REG_WDATA),
      .REG_WR     (REG_WR),
      .REG_RD     (REG_RD),
      .REG_RDATA  (REG_RDATA)
   );

   always #2 REF_CLK = ~REF_CLK;

   // The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'h1;
      @(posedge REF_CLK);
      REG_WR <= 1'h0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      REG_ADDR <= a;
      REG_RD <= 1'h1;
      @(posedge REF_CLK);
      REG_RD <= 1'h0;
      #1;
      check(REG_RDATA, exp, "read data");
      @(posedge REF_CLK);
   endtask

   function automatic cache_op_protect_pkg::req_t mk(input int o, input logic [31:0] ea,
                                                     input logic [5:0] f, input logic [6:0] c);
      mk = '0;
      mk.op = cache_op_protect_pkg::op_t'(o);
      mk.ea = ea;
      {mk.zone_protection_field, mk.page_write_permit, mk.problem_state,
       mk.data_translation_enable, mk.tlb_hit} = f;
      mk.string_byte_count = c;
      mk.page_attr = 5'h0A;
   endfunction

   task automatic send(input cache_op_protect_pkg::req_t q);
      REQ <= q;
      REQ_VALID <= 1'h1;
      @(posedge REF_CLK);
      REQ_VALID <= 1'h0;
      #1;
      r = RESP;
      check(32'(RESP_VALID), 32'h0000_0001, "answer present");
      @(posedge REF_CLK);
   endtask

   // Flags are {fault, miss, no-op, perform, line fill}; only allocate may never fill.
   task automatic row(input int i, input logic [5:0] f, input logic [6:0] c,
                      input logic d, input logic m, input logic n);
      logic p;
      send(mk(i, 32'h1000_0000, f, c));
      p = !(d || m || n);
      check(32'(r[9:5]), 32'({d, m, n, p, p && i != 0}), "flags");
   endtask

   task automatic attr(input int o, input logic [31:0] ea, input logic [5:0] f,
                       input logic [4:0] e);
      send(mk(o, ea, f, 7'h04));
      check(32'(r.attr), 32'(e), "attributes");
   endtask

   initial begin
      repeat (2) @(posedge REF_CLK);
      SYS_RST <= 1'h0;
      @(posedge REF_CLK);
      for (int a = 0; a < 8; a++) begin
         reg_read(8'(a * 4), (a == 3) ? 32'hFFFF_FFFF : 32'h0000_0000);
      end
      reg_write(8'h1C, 32'hFFFF_FFFF);
      reg_read(8'h1C, 32'h0000_0000);
      $display("test register reset done");
      for (int i = 0; i < 15; i++) begin
         row(i, 6'h0F, 7'h04, ZONE_DSI[i], 1'h0, ZONE_NOP[i]);
         row(i, 6'h0B, 7'h04, 1'h0, 1'h0, 1'h0);
         row(i, 6'h13, 7'h04, WP_DSI[i], 1'h0, i == 0);
         row(i, 6'h1A, 7'h04, 1'h0, MISS[i], ZONE_NOP[i]);
         row(i, 6'h04, 7'h04, 1'h0, 1'h0, 1'h0);
      end
      row(13, 6'h06, 7'h00, 1'h0, 1'h0, 1'h1);
      row(14, 6'h06, 7'h00, 1'h0, 1'h0, 1'h1);
      // Ten faults and nine misses were provoked above; the count word is read-only.
      reg_write(8'h18, 32'hFFFF_FFFF);
      reg_read(8'h18, 32'h000A_0009);
      $display("test protection done");
      reg_write(8'h00, 32'h8000_0000);
      reg_write(8'h04, 32'h0000_0002);
      reg_write(8'h10, 32'h0000_0002);
      reg_write(8'h14, 32'h8000_0000);
      reg_read(8'h00, 32'h8000_0000);
      attr(1, 32'hF800_0000, 6'h04, 5'h1D);
      attr(1, 32'h0800_0000, 6'h04, 5'h06);
      attr(1, 32'h07FF_FFFF, 6'h04, 5'h0C);
      attr(10, 32'h0800_0000, 6'h04, 5'h0E);
      attr(1, 32'hF800_0000, 6'h1B, 5'h0A);
      reg_write(8'h0C, 32'h7FFF_FFFF);
      attr(1, 32'hF800_0000, 6'h04, 5'h19);
      $display("test attributes done");
      final_report();
   end
endmodule
